// *** include/ptprtc_pkg.sv ***
// Constants of the precision real-time clock control block
// Operation
// R1 - Read bit snapshots live time into registers
// R2 - Load bit copies registers into live time
// R3 - Reset bit zeroes time, then self-clears
// R4 - Continuous adjust applies rate each base cycle
// R5 - Rate direction bit sets correction sign
// R6 - Time advances only while enable bit set
// R7 - Step direction zero subtracts step value
// R8 - Phase code counts 8ns slots, 0 to 4; live phase is the 10ns residue, 0 to 3
// R9 - Phase codes 5 to 7 never produced
// R10 - Nanoseconds split into high and low words
// R11 - Seconds high word holds bits 31:16
// R12 - Step bit applies step value once, self-clears
// R13 - Seconds low word holds bits 15:0
// R14 - Direction one adds, zero subtracts rate
// R15 - Snapshot fields captured together, held stable
// R16 - Nanosecond wrap at one second bumps seconds
package ptprtc_pkg;
	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [11:0] ADDR_CONTROL = 12'h500;
	localparam logic [11:0] ADDR_PHASE   = 12'h502;
	localparam logic [11:0] ADDR_NS_HI   = 12'h504;
	localparam logic [11:0] ADDR_NS_LO   = 12'h506;
	localparam logic [11:0] ADDR_SEC_HI  = 12'h508;
	localparam logic [11:0] ADDR_SEC_LO  = 12'h50A;
	localparam logic [11:0] ADDR_RATE_HI = 12'h50C;
	localparam logic [11:0] ADDR_RATE_LO = 12'h50E;
	// ---------------------------------------------------------------
	// Field positions and masks
	// ---------------------------------------------------------------
	localparam int          CTL_RESET    = 0;
	localparam int          CTL_ENABLE   = 1;
	localparam int          CTL_CONT     = 2;
	localparam int          CTL_LOAD     = 3;
	localparam int          CTL_READ     = 4;
	localparam int          CTL_STEP_DIR = 5;
	localparam int          CTL_STEP     = 6;
	localparam int          RATE_DIR     = 15;
	localparam logic [15:0] CTL_WR_MASK  = 16'h807F;
	localparam logic [15:0] CTL_SC_MASK  = 16'h0059;
	localparam logic [15:0] REG_RESET    = 16'h0000;
	localparam logic [2:0]  PHASE_MAX    = 3'h4;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int          SYS_CLK_NS   = 50;
	localparam int          TICK_UNIT_NS = 10;
	localparam int          BASE_NS      = 40;
	localparam int          SYS_UNITS    = SYS_CLK_NS / TICK_UNIT_NS;
	localparam int          BASE_UNITS   = BASE_NS / TICK_UNIT_NS;
	localparam logic [31:0] BASE_NS_W    = 32'h0000_0028;
	localparam logic [31:0] NS_PER_SEC   = 32'h3B9A_CA00;
endpackage

// *** src/ptprtc_base_tick.sv ***
// Base-cycle counter and 10ns phase residue tracker for the real-time clock
`timescale 1ns/100ps
`default_nettype none
module ptprtc_base_tick #(
	parameter int SYS_UNITS  = ptprtc_pkg::SYS_UNITS,
	parameter int BASE_UNITS = ptprtc_pkg::BASE_UNITS
) (
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_run,
	input  wire logic       i_clear,
	input  wire logic       i_load,
	input  wire logic [2:0] i_load_phase,
	output logic      [1:0] o_cycles,
	output logic      [2:0] o_phase
);
	// Elaboration guard: 2-bit residue, at most two base cycles per clock
	if (BASE_UNITS != 4 || SYS_UNITS < 4 || SYS_UNITS > 7) begin : g_bad
		$error("ptprtc_base_tick: unsupported clock ratio");
	end

	logic [1:0] acc_q;
	logic [1:0] acc_d;
	logic [1:0] load_acc;
	logic [3:0] sum;

	// Residue in 10ns units; wraps count whole 40ns base cycles
	assign sum      = {2'h0, acc_q} + 4'(SYS_UNITS);
	assign o_cycles = i_run ? sum[3:2] : 2'h0; // see R4
	assign o_phase  = {1'b0, acc_q};            // see R8

	// Phase code to residue, floor of 8ns steps in 10ns units
	assign load_acc = (i_load_phase == 3'h0) ? 2'h0 :
	                  (i_load_phase == 3'h1) ? 2'h0 :
	                  (i_load_phase == 3'h2) ? 2'h1 :
	                  (i_load_phase == 3'h3) ? 2'h2 : 2'h3;

	assign acc_d = i_clear ? 2'h0 : i_load ? load_acc : i_run ? sum[1:0] : acc_q;

	// Residue register
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n)
			acc_q <= 2'h0;
		else
			acc_q <= acc_d;
	end
endmodule
`default_nettype wire

// *** src/ptprtc_time_add.sv ***
// Seconds, nanoseconds and fraction adder with one-second wrap
`timescale 1ns/100ps
`default_nettype none
module ptprtc_time_add (
	input  wire logic        i_sub_op,
	input  wire logic [31:0] i_ns,
	input  wire logic [31:0] i_sec,
	input  wire logic [31:0] i_frac,
	input  wire logic [31:0] i_d_ns,
	input  wire logic [31:0] i_d_frac,
	output logic      [31:0] o_ns,
	output logic      [31:0] o_sec,
	output logic      [31:0] o_frac
);
	logic [32:0] frac_sum;
	logic [32:0] frac_dif;
	logic [33:0] ns_sum;
	logic [33:0] ns_dif;
	logic [33:0] sum_fix;
	logic [33:0] dif_fix;
	logic        sum_wrap;
	logic        dif_wrap;

	// Fraction carry or borrow ripples into nanoseconds
	assign frac_sum = {1'b0, i_frac} + {1'b0, i_d_frac};
	assign frac_dif = {1'b0, i_frac} - {1'b0, i_d_frac};
	assign ns_sum   = {2'h0, i_ns} + {2'h0, i_d_ns} + {33'h0, frac_sum[32]};
	assign ns_dif   = {2'h0, i_ns} - {2'h0, i_d_ns} - {33'h0, frac_dif[32]};

	// One-second wrap in either direction moves the seconds count
	assign sum_wrap = ns_sum >= {2'h0, ptprtc_pkg::NS_PER_SEC}; // see R16
	assign dif_wrap = ns_dif[33];
	assign sum_fix  = sum_wrap ? ns_sum - {2'h0, ptprtc_pkg::NS_PER_SEC} : ns_sum;
	assign dif_fix  = dif_wrap ? ns_dif + {2'h0, ptprtc_pkg::NS_PER_SEC} : ns_dif;

	// Result select
	assign o_frac = i_sub_op ? frac_dif[31:0] : frac_sum[31:0];
	assign o_ns   = i_sub_op ? dif_fix[31:0] : sum_fix[31:0];
	assign o_sec  = i_sub_op ? i_sec - {31'h0, dif_wrap} : i_sec + {31'h0, sum_wrap};
endmodule
`default_nettype wire

// *** src/ptprtc_rtc_ctrl.sv ***
// Precision real-time clock with control, time and rate registers
`timescale 1ns/100ps
`default_nettype none
module ptprtc_rtc_ctrl (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_n,
	input  wire logic [11:0] i_addr,
	input  wire logic [15:0] i_wr_data,
	input  wire logic        i_wr_en,
	input  wire logic        i_rd_en,
	output logic      [15:0] o_rd_data,
	output logic      [31:0] o_rtc_ns,
	output logic      [31:0] o_rtc_sec
);
	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [15:0] ctrl_q;
	logic [15:0] ctrl_d;
	logic [2:0]  ph_q;
	logic [2:0]  ph_d;
	logic [15:0] nsh_q;
	logic [15:0] nsh_d;
	logic [15:0] nsl_q;
	logic [15:0] nsl_d;
	logic [15:0] sech_q;
	logic [15:0] sech_d;
	logic [15:0] secl_q;
	logic [15:0] secl_d;
	logic [15:0] rth_q;
	logic [15:0] rth_d;
	logic [15:0] rtl_q;
	logic [15:0] rtl_d;
	logic [31:0] rtc_ns_q;
	logic [31:0] rtc_ns_d;
	logic [31:0] rtc_sec_q;
	logic [31:0] rtc_sec_d;
	logic [31:0] rtc_frac_q;
	logic [31:0] rtc_frac_d;
	logic [15:0] rd_q;
	logic [15:0] rd_mux;

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	logic wr_ctl;
	logic wr_ph;
	logic wr_nsh;
	logic wr_nsl;
	logic wr_sech;
	logic wr_secl;
	logic wr_rth;
	logic wr_rtl;

	// Write strobes per register
	assign wr_ctl  = i_wr_en && (i_addr == ptprtc_pkg::ADDR_CONTROL);
	assign wr_ph   = i_wr_en && (i_addr == ptprtc_pkg::ADDR_PHASE);
	assign wr_nsh  = i_wr_en && (i_addr == ptprtc_pkg::ADDR_NS_HI);
	assign wr_nsl  = i_wr_en && (i_addr == ptprtc_pkg::ADDR_NS_LO);
	assign wr_sech = i_wr_en && (i_addr == ptprtc_pkg::ADDR_SEC_HI);
	assign wr_secl = i_wr_en && (i_addr == ptprtc_pkg::ADDR_SEC_LO);
	assign wr_rth  = i_wr_en && (i_addr == ptprtc_pkg::ADDR_RATE_HI);
	assign wr_rtl  = i_wr_en && (i_addr == ptprtc_pkg::ADDR_RATE_LO);

	// ---------------------------------------------------------------
	// Control actions
	// ---------------------------------------------------------------
	logic        do_rst;
	logic        do_load;
	logic        do_step;
	logic        do_snap;
	logic        run;
	logic        cont;
	logic        rate_up;
	logic [29:0] rate;
	logic [31:0] hold_ns;
	logic [31:0] hold_sec;

	// Self-clearing bits act in the cycle after they are written
	assign do_rst   = ctrl_q[ptprtc_pkg::CTL_RESET];
	assign do_load  = ctrl_q[ptprtc_pkg::CTL_LOAD];
	assign do_step  = ctrl_q[ptprtc_pkg::CTL_STEP];
	assign do_snap  = ctrl_q[ptprtc_pkg::CTL_READ];
	assign run      = ctrl_q[ptprtc_pkg::CTL_ENABLE] && !do_rst && !do_load; // see R6
	assign cont     = ctrl_q[ptprtc_pkg::CTL_CONT];
	assign rate_up  = rth_q[ptprtc_pkg::RATE_DIR];
	assign rate     = {rth_q[13:0], rtl_q};
	assign hold_ns  = {nsh_q, nsl_q};   // see R10
	assign hold_sec = {sech_q, secl_q}; // see R11
	// New write wins, otherwise pulse bits drop after acting
	assign ctrl_d   = wr_ctl ? (i_wr_data & ptprtc_pkg::CTL_WR_MASK)
	                         : (ctrl_q & ~ptprtc_pkg::CTL_SC_MASK); // see R1 R2 R3 R12

	// ---------------------------------------------------------------
	// Base cycle tracking
	// ---------------------------------------------------------------
	logic [1:0] cycles;
	logic [2:0] live_phase;

	ptprtc_base_tick u_tick (
		.i_sys_clk    (i_sys_clk),
		.i_rst_n      (i_rst_n),
		.i_run        (run),
		.i_clear      (do_rst),
		.i_load       (do_load),
		.i_load_phase (ph_q),
		.o_cycles     (cycles),
		.o_phase      (live_phase)
	);

	// ---------------------------------------------------------------
	// Per-clock advance with rate correction
	// ---------------------------------------------------------------
	logic [31:0] rate_x;
	logic [31:0] adj_x;
	logic        adj_neg;
	logic [31:0] tick_dns;
	logic [31:0] tick_dfrac;
	logic [31:0] tick_ns;
	logic [31:0] tick_sec;
	logic [31:0] tick_frac;

	// Rate once per elapsed base cycle, signed by the direction bit
	assign rate_x     = (cycles == 2'h2) ? {1'b0, rate, 1'b0} :
	                    (cycles == 2'h1) ? {2'h0, rate} : 32'h0000_0000;
	assign adj_x      = cont ? rate_x : 32'h0000_0000;       // see R4
	assign adj_neg    = !rate_up && (adj_x != 32'h0000_0000); // see R5 R14
	assign tick_dns   = ({30'h0, cycles} * ptprtc_pkg::BASE_NS_W) - {31'h0, adj_neg};
	assign tick_dfrac = adj_neg ? (32'h0000_0000 - adj_x) : adj_x;

	ptprtc_time_add u_tick_add (
		.i_sub_op (1'b0),
		.i_ns     (rtc_ns_q),
		.i_sec    (rtc_sec_q),
		.i_frac   (rtc_frac_q),
		.i_d_ns   (tick_dns),
		.i_d_frac (tick_dfrac),
		.o_ns     (tick_ns),
		.o_sec    (tick_sec),
		.o_frac   (tick_frac)
	);

	// ---------------------------------------------------------------
	// Step adjustment on top of the advance
	// ---------------------------------------------------------------
	logic [31:0] step_ns;
	logic [31:0] step_sec;
	logic [31:0] step_frac;
	logic        step_sub;

	assign step_sub = !ctrl_q[ptprtc_pkg::CTL_STEP_DIR]; // see R7

	ptprtc_time_add u_step_add (
		.i_sub_op (step_sub),
		.i_ns     (tick_ns),
		.i_sec    (tick_sec),
		.i_frac   (tick_frac),
		.i_d_ns   (hold_ns),
		.i_d_frac (32'h0000_0000),
		.o_ns     (step_ns),
		.o_sec    (step_sec),
		.o_frac   (step_frac)
	);

	// Time select: reset, then load, then step, then plain advance
	assign rtc_ns_d   = do_rst ? 32'h0000_0000 : do_load ? hold_ns :
	                    do_step ? step_ns : tick_ns;          // see R2 R3 R12
	assign rtc_sec_d  = do_rst ? 32'h0000_0000 : do_load ? hold_sec :
	                    do_step ? step_sec : tick_sec;        // see R16
	assign rtc_frac_d = (do_rst || do_load) ? 32'h0000_0000 :
	                    do_step ? step_frac : tick_frac;

	// ---------------------------------------------------------------
	// Time registers; snapshot beats a same-cycle software write
	// ---------------------------------------------------------------
	assign ph_d   = do_snap ? live_phase : wr_ph ? i_wr_data[2:0] : ph_q; // see R1 R8 R9
	assign nsh_d  = do_snap ? rtc_ns_q[31:16] : wr_nsh ? i_wr_data : nsh_q; // see R15
	assign nsl_d  = do_snap ? rtc_ns_q[15:0] : wr_nsl ? i_wr_data : nsl_q;
	assign sech_d = do_snap ? rtc_sec_q[31:16] : wr_sech ? i_wr_data : sech_q;
	assign secl_d = do_snap ? rtc_sec_q[15:0] : wr_secl ? i_wr_data : secl_q; // see R13
	assign rth_d  = wr_rth ? i_wr_data : rth_q;
	assign rtl_d  = wr_rtl ? i_wr_data : rtl_q;

	// Read select; unmapped and reserved bits read zero
	assign rd_mux = (i_addr == ptprtc_pkg::ADDR_CONTROL) ? ctrl_q :
	                (i_addr == ptprtc_pkg::ADDR_PHASE)   ? {13'h0000, ph_q} :
	                (i_addr == ptprtc_pkg::ADDR_NS_HI)   ? nsh_q :
	                (i_addr == ptprtc_pkg::ADDR_NS_LO)   ? nsl_q :
	                (i_addr == ptprtc_pkg::ADDR_SEC_HI)  ? sech_q :
	                (i_addr == ptprtc_pkg::ADDR_SEC_LO)  ? secl_q :
	                (i_addr == ptprtc_pkg::ADDR_RATE_HI) ? rth_q :
	                (i_addr == ptprtc_pkg::ADDR_RATE_LO) ? rtl_q : 16'h0000;

	// Register bank
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			ctrl_q <= ptprtc_pkg::REG_RESET;
			ph_q   <= 3'h0;
			nsh_q  <= ptprtc_pkg::REG_RESET;
			nsl_q  <= ptprtc_pkg::REG_RESET;
			sech_q <= ptprtc_pkg::REG_RESET;
			secl_q <= ptprtc_pkg::REG_RESET;
			rth_q  <= ptprtc_pkg::REG_RESET;
			rtl_q  <= ptprtc_pkg::REG_RESET;
		end else begin
			ctrl_q <= ctrl_d;
			ph_q   <= ph_d;
			nsh_q  <= nsh_d;
			nsl_q  <= nsl_d;
			sech_q <= sech_d;
			secl_q <= secl_d;
			rth_q  <= rth_d;
			rtl_q  <= rtl_d;
		end
	end

	// Live time
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			rtc_ns_q   <= 32'h0000_0000;
			rtc_sec_q  <= 32'h0000_0000;
			rtc_frac_q <= 32'h0000_0000;
		end else begin
			rtc_ns_q   <= rtc_ns_d;
			rtc_sec_q  <= rtc_sec_d;
			rtc_frac_q <= rtc_frac_d;
		end
	end

	// Read data stands for one cycle only
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n)
			rd_q <= 16'h0000;
		else
			rd_q <= i_rd_en ? rd_mux : 16'h0000;
	end

	assign o_rd_data = rd_q;
	assign o_rtc_ns  = rtc_ns_q;
	assign o_rtc_sec = rtc_sec_q;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);

	logic quiet;
	logic tick_only;

	// No pulse bit pending and no control write
	assign quiet     = ((ctrl_q & ptprtc_pkg::CTL_SC_MASK) == 16'h0000) && !wr_ctl;
	assign tick_only = quiet && ctrl_q[ptprtc_pkg::CTL_ENABLE] && !cont;

	chk_read_snap: assert property ( // see R1
		do_snap && !wr_ctl |=> !do_snap && hold_ns == $past(rtc_ns_q)
			&& hold_sec == $past(rtc_sec_q))
		else $error("snapshot did not copy live time");

	chk_snap_hold: assert property ( // see R15
		quiet && !i_wr_en ##1 quiet && !i_wr_en |=> $stable(hold_ns) && $stable(hold_sec))
		else $error("snapshot registers changed without cause");

	chk_load_time: assert property ( // see R2
		do_load && !do_rst |=> rtc_ns_q == $past(hold_ns) && rtc_sec_q == $past(hold_sec))
		else $error("load did not copy registers into time");

	chk_reset_zero: assert property ( // see R3
		do_rst && !wr_ctl |=> rtc_ns_q == 32'h0 && rtc_sec_q == 32'h0 && !do_rst)
		else $error("clock reset did not zero time");

	chk_hold_still: assert property ( // see R6
		quiet && !ctrl_q[ptprtc_pkg::CTL_ENABLE] |=> $stable(rtc_ns_q) && $stable(rtc_sec_q))
		else $error("time moved while disabled");

	chk_run_advance: assert property ( // see R6
		tick_only && rtc_ns_q < 32'd999_000_000
		|=> (rtc_ns_q - $past(rtc_ns_q)) == 32'd40 || (rtc_ns_q - $past(rtc_ns_q)) == 32'd80)
		else $error("enabled time did not advance by base cycles");

	chk_no_adjust: assert property ( // see R4
		tick_only |=> $stable(rtc_frac_q))
		else $error("correction applied while adjustment off");

	chk_rate_add: assert property ( // see R5 R14
		quiet && run && cont && rate_up && rate != 30'h0 && rtc_frac_q < 32'h4000_0000
		|=> rtc_frac_q > $past(rtc_frac_q))
		else $error("positive rate did not add");

	chk_rate_sub: assert property ( // see R5 R14
		quiet && run && cont && !rate_up && rate != 30'h0 && rtc_frac_q >= 32'h8000_0000
		|=> rtc_frac_q < $past(rtc_frac_q))
		else $error("negative rate did not subtract");

	chk_step_dir: assert property ( // see R7 R12
		do_step && step_sub && !do_load && !do_rst && !run && rtc_ns_q >= hold_ns
		|=> rtc_ns_q == $past(rtc_ns_q) - $past(hold_ns) && $stable(rtc_sec_q))
		else $error("step with direction zero did not subtract");

	chk_phase_valid: assert property ( // see R8 R9
		(live_phase <= ptprtc_pkg::PHASE_MAX) and (do_snap |=> ph_q <= ptprtc_pkg::PHASE_MAX))
		else $error("invalid phase code produced");

	// A 40 ns step from 40 ns below the second is the smallest that must wrap
	chk_sec_wrap: assert property ( // see R16
		tick_only && rtc_ns_q >= 32'd999_999_960 && rtc_ns_q < ptprtc_pkg::NS_PER_SEC
		|=> rtc_ns_q < 32'd80 && rtc_sec_q == $past(rtc_sec_q) + 32'd1)
		else $error("second wrap missed");

	chk_rd_pulse: assert property ( // see R10
		i_rd_en && i_addr == ptprtc_pkg::ADDR_NS_HI |=> o_rd_data == $past(nsh_q)
			##1 (o_rd_data == 16'h0000 || $past(i_rd_en)))
		else $error("read data timing wrong");

	cov_snapshot: cover property (wr_ctl && i_wr_data[ptprtc_pkg::CTL_READ] ##1 do_snap);
	cov_load: cover property (do_load ##1 run);
	cov_step: cover property (do_step && step_sub);
	cov_wrap: cover property (run && rtc_sec_q != $past(rtc_sec_q));
endmodule
`default_nettype wire

// *** tb/ptprtc_rtc_ctrl_tb_top.sv ***
// Self-checking testbench for the precision real-time clock control block
`timescale 1ns/100ps
`default_nettype none
module ptprtc_rtc_ctrl_tb_top;
	// ---------------------------------------------------------------
	// Signals and design instance
	// ---------------------------------------------------------------
	logic        i_sys_clk;
	logic        i_rst_n;
	logic [11:0] i_addr;
	logic [15:0] i_wr_data;
	logic        i_wr_en;
	logic        i_rd_en;
	logic [15:0] o_rd_data;
	logic [31:0] o_rtc_ns;
	logic [31:0] o_rtc_sec;
	int          err_count;
	int          samples_checked;
	logic [15:0] rdat;

	// Control bit values used by the scenarios
	localparam logic [15:0] C_RST  = 16'h0001 << ptprtc_pkg::CTL_RESET;
	localparam logic [15:0] C_EN   = 16'h0001 << ptprtc_pkg::CTL_ENABLE;
	localparam logic [15:0] C_CONT = 16'h0001 << ptprtc_pkg::CTL_CONT;
	localparam logic [15:0] C_LOAD = 16'h0001 << ptprtc_pkg::CTL_LOAD;
	localparam logic [15:0] C_READ = 16'h0001 << ptprtc_pkg::CTL_READ;
	localparam logic [15:0] C_SDIR = 16'h0001 << ptprtc_pkg::CTL_STEP_DIR;
	localparam logic [15:0] C_STEP = 16'h0001 << ptprtc_pkg::CTL_STEP;

	ptprtc_rtc_ctrl uut (
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (i_rst_n),
		.i_addr    (i_addr),
		.i_wr_data (i_wr_data),
		.i_wr_en   (i_wr_en),
		.i_rd_en   (i_rd_en),
		.o_rd_data (o_rd_data),
		.o_rtc_ns  (o_rtc_ns),
		.o_rtc_sec (o_rtc_sec)
	);

	// 20 MHz clock
	always #25 i_sys_clk = ~i_sys_clk;

	// ---------------------------------------------------------------
	// Bus and check tasks (entered right after a rising edge)
	// ---------------------------------------------------------------
	// Write strobe stays up for back-to-back writes; idle or rd drops it
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		i_addr    <= a;
		i_wr_data <= d;
		i_wr_en   <= 1'b1;
		@(posedge i_sys_clk);
	endtask

	// Drop both strobes and let n edges pass
	task automatic idle(input int n);
		i_wr_en <= 1'b0;
		i_rd_en <= 1'b0;
		repeat (n) @(posedge i_sys_clk);
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [11:0] a, output logic [15:0] d);
		i_addr  <= a;
		i_wr_en <= 1'b0;
		i_rd_en <= 1'b1;
		@(posedge i_sys_clk);
		i_rd_en <= 1'b0;
		#1 d = o_rd_data;
		@(posedge i_sys_clk);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
			err_count++;
		end
	endtask

	task automatic chk_rd(input logic [11:0] a, input logic [15:0] exp);
		rd(a, rdat);
		chk({16'h0000, rdat}, {16'h0000, exp});
	endtask

	task automatic chk_time(input logic [31:0] ns, input logic [31:0] sec);
		chk(o_rtc_ns, ns);
		chk(o_rtc_sec, sec);
	endtask

	// Program time registers and fire the load bit with the clock stopped
	task automatic load(input logic [15:0] ph, input logic [31:0] ns, input logic [31:0] sec);
		wr(ptprtc_pkg::ADDR_PHASE, ph);
		wr(ptprtc_pkg::ADDR_NS_HI, ns[31:16]);
		wr(ptprtc_pkg::ADDR_NS_LO, ns[15:0]);
		wr(ptprtc_pkg::ADDR_SEC_HI, sec[31:16]);
		wr(ptprtc_pkg::ADDR_SEC_LO, sec[15:0]);
		wr(ptprtc_pkg::ADDR_CONTROL, C_LOAD);
		idle(2);
	endtask

	// Run the clock for exactly eight cycles, 400 ns of time
	task automatic run8(input logic [15:0] ctl);
		wr(ptprtc_pkg::ADDR_CONTROL, ctl | C_EN);
		idle(7);
		wr(ptprtc_pkg::ADDR_CONTROL, ctl);
		idle(2);
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset_values();
		for (int k = 0; k < 8; k++) begin
			chk_rd(ptprtc_pkg::ADDR_CONTROL + 12'(2 * k), 16'h0000);
		end
		wr(12'h510, 16'hFFFF);
		chk_rd(12'h510, 16'h0000);
		wr(ptprtc_pkg::ADDR_PHASE, 16'hFFFF);
		chk_rd(ptprtc_pkg::ADDR_PHASE, 16'h0007);
		wr(ptprtc_pkg::ADDR_CONTROL, 16'hFFA6);
		chk_rd(ptprtc_pkg::ADDR_CONTROL, 16'h8026);
		wr(ptprtc_pkg::ADDR_CONTROL, 16'h0000);
	endtask

	// Load, then stopped clock must hold, then a run advances by 400 ns
	task automatic t_load_enable();
		load(16'h0000, 32'h0000_1000, 32'h0000_0007);
		chk_time(32'h0000_1000, 32'h0000_0007);
		idle(8);
		chk_time(32'h0000_1000, 32'h0000_0007);
		run8(16'h0000);
		chk_time(32'h0000_1190, 32'h0000_0007);
		chk_rd(ptprtc_pkg::ADDR_CONTROL, 16'h0000);
	endtask

	// Snapshot overwrites stale register contents with one coherent time
	task automatic t_snapshot();
		load(16'h0000, 32'h1234_5678, 32'hABCD_0123);
		run8(16'h0000);
		wr(ptprtc_pkg::ADDR_NS_HI, 16'hFFFF);
		wr(ptprtc_pkg::ADDR_SEC_LO, 16'hFFFF);
		wr(ptprtc_pkg::ADDR_CONTROL, C_READ);
		chk_rd(ptprtc_pkg::ADDR_CONTROL, C_READ);
		chk_rd(ptprtc_pkg::ADDR_CONTROL, 16'h0000);
		idle(4);
		chk_rd(ptprtc_pkg::ADDR_PHASE, 16'h0000);
		chk_rd(ptprtc_pkg::ADDR_NS_HI, 16'h1234);
		chk_rd(ptprtc_pkg::ADDR_NS_LO, 16'h5808);
		chk_rd(ptprtc_pkg::ADDR_SEC_HI, 16'hABCD);
		chk_rd(ptprtc_pkg::ADDR_SEC_LO, 16'h0123);
	endtask

	// Step up, step down, step below zero borrows a second, then reset
	task automatic t_step_reset();
		load(16'h0000, 32'h0000_03E8, 32'h0000_0003);
		wr(ptprtc_pkg::ADDR_NS_HI, 16'h0000);
		wr(ptprtc_pkg::ADDR_NS_LO, 16'h01F4);
		wr(ptprtc_pkg::ADDR_CONTROL, C_STEP | C_SDIR);
		idle(2);
		chk_time(32'h0000_05DC, 32'h0000_0003);
		chk_rd(ptprtc_pkg::ADDR_CONTROL, C_SDIR);
		wr(ptprtc_pkg::ADDR_CONTROL, C_STEP);
		idle(2);
		chk_time(32'h0000_03E8, 32'h0000_0003);
		wr(ptprtc_pkg::ADDR_NS_LO, 16'h0514);
		wr(ptprtc_pkg::ADDR_CONTROL, C_STEP);
		idle(2);
		chk_time(32'h3B9A_C8D4, 32'h0000_0002);
		wr(ptprtc_pkg::ADDR_CONTROL, C_RST);
		idle(2);
		chk_time(32'h0000_0000, 32'h0000_0000);
		chk_rd(ptprtc_pkg::ADDR_CONTROL, 16'h0000);
	endtask

	// Running across the one-second boundary carries into seconds
	task automatic t_wrap();
		load(16'h0000, 32'h3B9A_C9F6, 32'h0000_0005);
		run8(16'h0000);
		chk_time(32'h0000_0186, 32'h0000_0006);
	endtask

	// Rate off, rate added, rate subtracted over ten base cycles
	task automatic t_rate();
		logic [31:0] exp_ns[3];
		exp_ns = '{32'h0000_0578, 32'h0000_057A, 32'h0000_0575};
		for (int m = 0; m < 3; m++) begin
			load(16'h0000, 32'h0000_03E8, 32'h0000_0000);
			wr(ptprtc_pkg::ADDR_RATE_HI, (m == 2) ? 16'h3FFF : 16'hBFFF);
			wr(ptprtc_pkg::ADDR_RATE_LO, 16'hFFFF);
			run8((m == 0) ? 16'h0000 : C_CONT);
			chk_time(exp_ns[m], 32'h0000_0000);
		end
	endtask

	// Loaded 32ns phase sits on the 30ns residue, snapshot reports slot 3
	task automatic t_phase_load();
		load(16'h0004, 32'h0000_0100, 32'h0000_0000);
		wr(ptprtc_pkg::ADDR_CONTROL, C_READ);
		idle(2);
		chk_rd(ptprtc_pkg::ADDR_PHASE, 16'h0003);
		chk_rd(ptprtc_pkg::ADDR_NS_LO, 16'h0100);
	endtask

	// ---------------------------------------------------------------
	// Verdict, watchdog and main sequence
	// ---------------------------------------------------------------
	task automatic test_done();
		$display("Checks made: %0d, mismatches: %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Whole run needs well under 1000 cycles
	initial begin
		#1_000_000;
		err_count++;
		test_done();
	end

	// Reset for twelve cycles, then the scenarios in turn
	initial begin
		i_sys_clk       = 1'b0;
		i_rst_n         = 1'b0;
		i_addr          = 12'h000;
		i_wr_data       = 16'h0000;
		i_wr_en         = 1'b0;
		i_rd_en         = 1'b0;
		err_count       = 0;
		samples_checked = 0;
		repeat (12) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		@(posedge i_sys_clk);
		t_reset_values();
		t_load_enable();
		t_snapshot();
		t_step_reset();
		t_wrap();
		t_rate();
		t_phase_load();
		test_done();
	end
endmodule
`default_nettype wire
